// ==== logic/fbm_boot_ctrl.sv ====
`timescale 1ns/1ns
// Overview of operation
// - primary mode pin low at reset release selects normal run, secondary pin ignored.
// - primary high and secondary low enters programming; both high is prohibited.
// - in programming mode every pin not used by the programmer keeps its reset state.
// - async uses tx/rx, clocked modes use out/in/clock, handshake modes add one port pin.
// - a flash service interface lets code running from RAM erase and rewrite flash.
// - a boot swap exchanges blocks 0-15 with blocks 16-31, higher blocks unchanged.
// - parts with 16 KB or 32 KB of flash have no boot swap.
// - no instruction fetch from flash while self-programming runs.
// - during self-programming NMI vectors to RAM start and maskable interrupts to start+4.
// - pulses on the primary pin pick the interface: 0, 8, 9, 11, 12; others prohibited.
module fbm_boot_ctrl
    import fbm_pkg::*;
#(
    parameter int FLASH_KB = FBM_FLASH_KB_DEF,
    parameter logic [31:0] RAM_BASE = FBM_RAM_BASE_DEF,
    parameter int SETTLE_CYC = FBM_SETTLE_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // mode pins
    input wire logic modeSelectPrimary,
    input wire logic modeSelectSecondary,
    input wire logic debugResetIn,
    // self-programming service
    input wire logic selfProgStart,
    input wire logic selfProgEnd,
    input wire logic bootSwapReq,
    input wire logic [7:0] fetchBlock,
    // mode and pin-routing status
    output logic progMode,
    output logic normalMode,
    output logic modeError,
    output logic asyncPinsEn,
    output logic serialAPinsEn,
    output logic serialBPinsEn,
    output logic handshakePinEn,
    output logic pinsHoldReset,
    output logic ifSelected,
    output logic ifError,
    output logic debugResetFault,
    // flash mapping and fetch
    output logic selfProgBusy,
    output logic flashFetchBlock,
    output logic swapActive,
    output logic [7:0] physBlock,
    output logic [31:0] nmiVector,
    output logic [31:0] maskVector
);
    // ------------------------------------------------------------
    // synchronisers for external pins
    // ------------------------------------------------------------
    logic [2:0] syncA_r;
    logic [2:0] syncB_r;
    logic prevPrim_r;
    always_ff @(posedge ref_clk) begin
        syncA_r <= {debugResetIn, modeSelectSecondary, modeSelectPrimary};
        syncB_r <= syncA_r;
        prevPrim_r <= syncB_r[0];
    end
    wire logic primS = syncB_r[0];
    wire logic secS = syncB_r[1];
    wire logic drstS = syncB_r[2];

    // ------------------------------------------------------------
    // mode latch and interface selection
    // ------------------------------------------------------------
    localparam bit SWAP_OK = (FLASH_KB > FBM_NOSWAP_KB);

    fbm_mode_t mode_r, mode_nxt;
    fbm_if_t if_r, if_nxt;
    logic sampled_r, sampled_nxt;
    logic [3:0] pulses_r, pulses_nxt;
    logic [15:0] settle_r, settle_nxt;
    logic ifErr_r, ifErr_nxt;
    logic drstErr_r, drstErr_nxt;

    function automatic fbm_if_t decodeIf(input logic [3:0] n);
        case (n)
            FBM_PULSES_ASYNC: decodeIf = FBM_IF_ASYNC;
            FBM_PULSES_SERA: decodeIf = FBM_IF_SERA;
            FBM_PULSES_SERB: decodeIf = FBM_IF_SERB;
            FBM_PULSES_SERA_HS: decodeIf = FBM_IF_SERA_HS;
            FBM_PULSES_SERB_HS: decodeIf = FBM_IF_SERB_HS;
            default: decodeIf = FBM_IF_NONE;
        endcase
    endfunction

    always_comb begin
        mode_nxt = mode_r;
        if_nxt = if_r;
        sampled_nxt = 1'b1;
        pulses_nxt = pulses_r;
        settle_nxt = settle_r;
        ifErr_nxt = ifErr_r;
        drstErr_nxt = drstErr_r;
        // pins are taken on the first clock after reset release, from synchroniser values sampled while reset was still held
        if (!sampled_r) begin
            if (!primS) begin
                mode_nxt = FBM_MODE_NORMAL;
            end else if (!secS) begin
                mode_nxt = FBM_MODE_PROG;
            end else begin
                mode_nxt = FBM_MODE_BAD;
            end
        end
        if (mode_r == FBM_MODE_PROG && if_r == FBM_IF_NONE && !ifErr_r) begin
            if (primS && !prevPrim_r && sampled_r) begin
                settle_nxt = 16'h0000;
                if (pulses_r == FBM_PULSES_MAX) begin
                    ifErr_nxt = 1'b1;
                end else begin
                    pulses_nxt = pulses_r + 4'h1;
                end
            end else if (settle_r == 16'(SETTLE_CYC - 1)) begin
                if_nxt = decodeIf(pulses_r);
                ifErr_nxt = (decodeIf(pulses_r) == FBM_IF_NONE);
            end else begin
                settle_nxt = settle_r + 16'h0001;
            end
        end
        // a high debug reset during programming is reported, never obeyed
        if (mode_r == FBM_MODE_PROG && drstS) begin
            drstErr_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_r <= FBM_MODE_NORMAL;
            if_r <= FBM_IF_NONE;
            sampled_r <= 1'b0;
            pulses_r <= 4'h0;
            settle_r <= 16'h0000;
            ifErr_r <= 1'b0;
            drstErr_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            if_r <= if_nxt;
            sampled_r <= sampled_nxt;
            pulses_r <= pulses_nxt;
            settle_r <= settle_nxt;
            ifErr_r <= ifErr_nxt;
            drstErr_r <= drstErr_nxt;
        end
    end

    // ------------------------------------------------------------
    // self-programming state and boot swap
    // ------------------------------------------------------------
    logic busy_r, busy_nxt;
    logic swap_r, swap_nxt;

    always_comb begin
        busy_nxt = busy_r;
        swap_nxt = swap_r;
        // self-programming only from normal run, code executing in RAM
        if (mode_r == FBM_MODE_NORMAL && sampled_r) begin
            if (selfProgStart) begin
                busy_nxt = 1'b1;
            end else if (selfProgEnd) begin
                busy_nxt = 1'b0;
            end
            if (busy_r && bootSwapReq && SWAP_OK) begin
                swap_nxt = !swap_r;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_r <= 1'b0;
            swap_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            swap_r <= swap_nxt;
        end
    end

    function automatic logic [7:0] mapBlock(input logic [7:0] b, input logic sw);
        // swap only touches the low 32 blocks
        if (sw && b < FBM_SWAP_LIMIT) begin
            mapBlock = b ^ FBM_SWAP_BIT;
        end else begin
            mapBlock = b;
        end
    endfunction

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            progMode <= 1'b0;
            normalMode <= 1'b0;
            modeError <= 1'b0;
            asyncPinsEn <= 1'b0;
            serialAPinsEn <= 1'b0;
            serialBPinsEn <= 1'b0;
            handshakePinEn <= 1'b0;
            pinsHoldReset <= 1'b0;
            ifSelected <= 1'b0;
            ifError <= 1'b0;
            debugResetFault <= 1'b0;
            selfProgBusy <= 1'b0;
            flashFetchBlock <= 1'b0;
            swapActive <= 1'b0;
            physBlock <= 8'h00;
            nmiVector <= 32'h0000_0000;
            maskVector <= 32'h0000_0000;
        end else begin
            progMode <= (mode_r == FBM_MODE_PROG) && sampled_r;
            normalMode <= (mode_r == FBM_MODE_NORMAL) && sampled_r;
            modeError <= (mode_r == FBM_MODE_BAD) && sampled_r;
            asyncPinsEn <= (if_r == FBM_IF_ASYNC);
            serialAPinsEn <= (if_r == FBM_IF_SERA) || (if_r == FBM_IF_SERA_HS);
            serialBPinsEn <= (if_r == FBM_IF_SERB) || (if_r == FBM_IF_SERB_HS);
            handshakePinEn <= (if_r == FBM_IF_SERA_HS) || (if_r == FBM_IF_SERB_HS);
            pinsHoldReset <= (mode_r != FBM_MODE_NORMAL) && sampled_r;
            ifSelected <= (if_r != FBM_IF_NONE);
            ifError <= ifErr_r;
            debugResetFault <= drstErr_r;
            selfProgBusy <= busy_r;
            flashFetchBlock <= busy_r;
            swapActive <= swap_r;
            physBlock <= mapBlock(fetchBlock, swap_r);
            nmiVector <= RAM_BASE;
            maskVector <= RAM_BASE + FBM_MI_OFFSET;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence seqPulse;
        primS && !prevPrim_r;
    endsequence

    AST_NORMAL_IGNORES_SEC: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(sampled_r) && !$past(primS) |-> mode_r == FBM_MODE_NORMAL)
        else $error("primary low did not give normal mode");
    AST_PROG_ENTRY: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(sampled_r) && $past(primS) && !$past(secS) |-> ##1 progMode)
        else $error("programming mode not entered");
    AST_MODE_HELD: assert property (@(posedge ref_clk) disable iff (srst)
        sampled_r && $past(sampled_r) |-> $stable(mode_r))
        else $error("mode changed without reset");
    AST_PINS_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        progMode |-> pinsHoldReset && !selfProgBusy)
        else $error("pins released in programming mode");
    AST_HS_ONLY_SERIAL: assert property (@(posedge ref_clk) disable iff (srst)
        handshakePinEn |-> (serialAPinsEn ^ serialBPinsEn) && !asyncPinsEn)
        else $error("handshake pin without clocked serial");
    AST_BAD_COUNT: assert property (@(posedge ref_clk) disable iff (srst)
        ifErr_r |-> ##2 (ifError && !ifSelected))
        else $error("prohibited pulse count accepted");
    AST_PULSE_COUNT: assert property (@(posedge ref_clk) disable iff (srst)
        seqPulse and (if_r == FBM_IF_NONE) and (pulses_r < FBM_PULSES_MAX) and !ifErr_r
        and (mode_r == FBM_MODE_PROG) and sampled_r |=> pulses_r == $past(pulses_r) + 4'h1)
        else $error("pulse not counted");
    AST_FETCH_BLOCKED: assert property (@(posedge ref_clk) disable iff (srst)
        busy_r |-> ##1 flashFetchBlock)
        else $error("flash fetch allowed during self-programming");
    AST_SWAP_MAP: assert property (@(posedge ref_clk) disable iff (srst)
        swap_r && fetchBlock < FBM_SWAP_LIMIT |=> physBlock == ($past(fetchBlock) ^ FBM_SWAP_BIT))
        else $error("boot swap mapping wrong");
    AST_NO_SWAP_SMALL: assert property (@(posedge ref_clk) disable iff (srst)
        (mode_r == FBM_MODE_NORMAL) && sampled_r && busy_r && bootSwapReq
        |=> swap_r == (SWAP_OK ? !$past(swap_r) : $past(swap_r)))
        else $error("boot swap toggle does not match flash size");
    AST_VECTORS: assert property (@(posedge ref_clk) disable iff (srst)
        selfProgBusy |-> nmiVector == RAM_BASE && maskVector == RAM_BASE + FBM_MI_OFFSET)
        else $error("interrupt vectors wrong");
    AST_DEBUG_RESET_IN: assert property (@(posedge ref_clk) disable iff (srst)
        (mode_r == FBM_MODE_PROG) && drstS |-> ##2 debugResetFault)
        else $error("debug reset high not flagged");
endmodule // fbm_boot_ctrl

// ==== logic/fbm_pkg.sv ====
package fbm_pkg;
    // ------------------------------------------------------------
    // operating modes latched at reset release
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FBM_MODE_NORMAL = 3'b001,
        FBM_MODE_PROG = 3'b010,
        FBM_MODE_BAD = 3'b100
    } fbm_mode_t;

    // ------------------------------------------------------------
    // programming interface selection
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        FBM_IF_NONE = 6'b000001,
        FBM_IF_ASYNC = 6'b000010,
        FBM_IF_SERA = 6'b000100,
        FBM_IF_SERB = 6'b001000,
        FBM_IF_SERA_HS = 6'b010000,
        FBM_IF_SERB_HS = 6'b100000
    } fbm_if_t;

    localparam int FBM_PULSE_W = 4;
    localparam logic [3:0] FBM_PULSES_ASYNC = 4'h0;
    localparam logic [3:0] FBM_PULSES_SERA = 4'h8;
    localparam logic [3:0] FBM_PULSES_SERB = 4'h9;
    localparam logic [3:0] FBM_PULSES_SERA_HS = 4'hb;
    localparam logic [3:0] FBM_PULSES_SERB_HS = 4'hc;
    localparam logic [3:0] FBM_PULSES_MAX = 4'hc;

    // window after the last pulse before the count is taken, in us
    localparam int FBM_SETTLE_US = 100;
    localparam int FBM_CLK_MHZ = 10;
    localparam int FBM_SETTLE_CYC = FBM_SETTLE_US * FBM_CLK_MHZ;

    // ------------------------------------------------------------
    // flash mapping and vectors
    // ------------------------------------------------------------
    localparam int FBM_BLK_W = 8;
    localparam logic [7:0] FBM_SWAP_BIT = 8'h10;
    localparam logic [7:0] FBM_SWAP_LIMIT = 8'h20;
    localparam int FBM_ADDR_W = 32;
    localparam logic [31:0] FBM_RAM_BASE_DEF = 32'h03ff_0000;
    localparam logic [31:0] FBM_MI_OFFSET = 32'h0000_0004;
    localparam int FBM_FLASH_KB_DEF = 256;
    localparam int FBM_NOSWAP_KB = 32;
endpackage

// ==== sim/fbm_boot_ctrl_tb_top.sv ====
`timescale 1ns/1ns
module fbm_boot_ctrl_tb_top;
    import fbm_pkg::*;
    localparam logic [31:0] RAM_B = 32'h0010_0000;
    logic ref_clk = 1'b0;
    logic spStart, spEnd, swapReq;
    logic [7:0] fetchBlock;
    wire logic srst, mP, mS, dbg;
    wire logic [7:0] physBlock;
    wire logic progMode, normalMode, modeError, aEn, sAEn, sBEn, hsEn, holdRst;
    wire logic ifSel, ifErr, dbgFault, busy, noFetch, swapAct;
    wire logic [31:0] nmiVec, maskVec;
    int nErrors = 0, numChecks = 0;

    always #50 ref_clk = ~ref_clk;

    fbm_prog_model i_prog (.ref_clk(ref_clk), .srst(srst), .modeSelectPrimary(mP),
        .modeSelectSecondary(mS), .debugResetIn(dbg));

    fbm_boot_ctrl #(.FLASH_KB(256), .RAM_BASE(RAM_B), .SETTLE_CYC(20)) i_dut (
        .ref_clk(ref_clk), .srst(srst), .modeSelectPrimary(mP),
        .modeSelectSecondary(mS), .debugResetIn(dbg), .selfProgStart(spStart),
        .selfProgEnd(spEnd), .bootSwapReq(swapReq), .fetchBlock(fetchBlock),
        .progMode(progMode), .normalMode(normalMode), .modeError(modeError),
        .asyncPinsEn(aEn), .serialAPinsEn(sAEn), .serialBPinsEn(sBEn),
        .handshakePinEn(hsEn), .pinsHoldReset(holdRst), .ifSelected(ifSel),
        .ifError(ifErr), .debugResetFault(dbgFault), .selfProgBusy(busy),
        .flashFetchBlock(noFetch), .swapActive(swapAct), .physBlock(physBlock),
        .nmiVector(nmiVec), .maskVector(maskVec));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            nErrors++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // bounded wait for the interface decision, then two cycles for the outputs
    task automatic wait_decision();
        for (int i = 0; i < 80 && ifSel !== 1'b1 && ifErr !== 1'b1; i++) begin
            i_prog.step(1);
        end
        i_prog.step(2);
    endtask

    task automatic t_normal();
        i_prog.reset_into(1'b0, 1'b1);
        check("normalMode", 32'h1, normalMode);
        check("progMode", 32'h0, progMode);
        check("modeError", 32'h0, modeError);
        i_prog.set_pins(1'b1, 1'b0);
        i_prog.step(8);
        check("normalMode held", 32'h1, normalMode);
        check("progMode held", 32'h0, progMode);
        i_prog.set_pins(1'b0, 1'b0);
        $display("test normal done");
    endtask

    task automatic t_interfaces();
        int cnt[5] = '{0, 8, 9, 11, 12};
        logic [3:0] pins[5] = '{4'h8, 4'h4, 4'h2, 4'h5, 4'h3};
        for (int k = 0; k < 5; k++) begin
            i_prog.reset_into(1'b1, 1'b0);
            check("progMode", 32'h1, progMode);
            check("pinsHoldReset", 32'h1, holdRst);
            i_prog.pulses(cnt[k]);
            wait_decision();
            check("ifSelected", 32'h1, ifSel);
            check("ifError", 32'h0, ifErr);
            check("pin sets", {28'h0, pins[k]}, {28'h0, aEn, sAEn, sBEn, hsEn});
            i_prog.pulses(2);
            check("pin sets kept", {28'h0, pins[k]}, {28'h0, aEn, sAEn, sBEn, hsEn});
        end
        $display("test interfaces done");
    endtask

    task automatic t_faults();
        i_prog.reset_into(1'b1, 1'b0);
        i_prog.pulses(5);
        wait_decision();
        check("ifError", 32'h1, ifErr);
        check("ifSelected", 32'h0, ifSel);
        check("debugResetFault", 32'h0, dbgFault);
        i_prog.set_pins(1'b1, 1'b1);
        i_prog.step(6);
        check("debugResetFault", 32'h1, dbgFault);
        i_prog.reset_into(1'b1, 1'b1);
        check("modeError", 32'h1, modeError);
        check("progMode", 32'h0, progMode);
        check("pinsHoldReset", 32'h1, holdRst);
        spStart = 1'b1;
        i_prog.step(1);
        spStart = 1'b0;
        i_prog.step(3);
        check("selfProgBusy outside normal", 32'h0, busy);
        i_prog.reset_into(1'b1, 1'b0);
        i_prog.pulses(13);
        wait_decision();
        check("ifError 13 pulses", 32'h1, ifErr);
        check("ifSelected 13 pulses", 32'h0, ifSel);
        $display("test faults done");
    endtask

    task automatic t_self_prog();
        i_prog.reset_into(1'b0, 1'b0);
        spStart = 1'b1;
        i_prog.step(1);
        spStart = 1'b0;
        i_prog.step(3);
        check("selfProgBusy", 32'h1, busy);
        check("flashFetchBlock", 32'h1, noFetch);
        check("nmiVector", RAM_B, nmiVec);
        check("maskVector", RAM_B + 32'h4, maskVec);
        swapReq = 1'b1;
        i_prog.step(1);
        swapReq = 1'b0;
        i_prog.step(3);
        check("swapActive", 32'h1, swapAct);
        fetchBlock = 8'h03;
        i_prog.step(3);
        check("physBlock lower", 32'h13, physBlock);
        fetchBlock = 8'h1f;
        i_prog.step(3);
        check("physBlock upper", 32'h0f, physBlock);
        fetchBlock = 8'h28;
        i_prog.step(3);
        check("physBlock high", 32'h28, physBlock);
        swapReq = 1'b1;
        i_prog.step(1);
        swapReq = 1'b0;
        i_prog.step(3);
        check("swapActive back", 32'h0, swapAct);
        fetchBlock = 8'h03;
        i_prog.step(3);
        check("physBlock unswapped", 32'h03, physBlock);
        spEnd = 1'b1;
        i_prog.step(1);
        spEnd = 1'b0;
        i_prog.step(3);
        check("selfProgBusy end", 32'h0, busy);
        check("flashFetchBlock end", 32'h0, noFetch);
        swapReq = 1'b1;
        i_prog.step(1);
        swapReq = 1'b0;
        i_prog.step(3);
        check("swapActive idle", 32'h0, swapAct);
        $display("test self programming done");
    endtask

    // generous span: all scenarios need well under 2000 cycles
    initial begin
        #2_000_000;
        nErrors++;
        wrap_up();
    end

    initial begin
        spStart = 1'b0;
        spEnd = 1'b0;
        swapReq = 1'b0;
        fetchBlock = 8'h00;
        t_normal();
        t_interfaces();
        t_faults();
        t_self_prog();
        wrap_up();
    end
endmodule // fbm_boot_ctrl_tb_top

// ==== sim/fbm_prog_model.sv ====
`timescale 1ns/1ns
module fbm_prog_model (
    // clock
    input wire logic ref_clk,
    // pins driven toward the device
    output logic srst,
    output logic modeSelectPrimary,
    output logic modeSelectSecondary,
    output logic debugResetIn
);
    initial begin
        srst = 1'b1;
        modeSelectPrimary = 1'b0;
        modeSelectSecondary = 1'b0;
        debugResetIn = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    // the programmer alone owns reset; pins stay put well around release
    task automatic reset_into(input logic p, input logic s);
        step(1);
        srst = 1'b1;
        modeSelectPrimary = p;
        modeSelectSecondary = s;
        debugResetIn = 1'b0;
        step(10);
        srst = 1'b0;
        step(4);
    endtask

    // each pulse is a dip of the primary pin, three cycles low and three high
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            modeSelectPrimary = 1'b0;
            step(3);
            modeSelectPrimary = 1'b1;
            step(3);
        end
    endtask

    task automatic set_pins(input logic p, input logic d);
        modeSelectPrimary = p;
        debugResetIn = d;
    endtask
endmodule // fbm_prog_model
